/* File: hw/teg_defs.vh */
// register map, field positions and codes for the timer event and compare block
`ifndef TEG_DEFS_VH
`define TEG_DEFS_VH

`define TEG_OFF_IEN      8'h0C
`define TEG_OFF_STS      8'h10
`define TEG_OFF_EVT      8'h14
`define TEG_OFF_MODE     8'h18
`define TEG_OFF_CCEN     8'h20
`define TEG_OFF_CC1      8'h34
`define TEG_OFF_CC2      8'h38

`define TEG_BIT_UPD      0
`define TEG_BIT_CC1      1
`define TEG_BIT_TRG      6
`define TEG_BIT_OC1      9

`define TEG_MODE_RST     16'h0000
`define TEG_IEN_MASK     16'h0047
`define TEG_CCEN_MASK    16'h00BB
`define TEG_CCEN_STRIDE  4
`define TEG_MODE_STRIDE  8

`define TEG_DIR_OUT      2'b00
`define TEG_DIR_OWN      2'b01
`define TEG_DIR_OTHER    2'b10
`define TEG_DIR_ITRIG    2'b11

`define TEG_OC_FROZEN    3'b000
`define TEG_OC_SET       3'b001
`define TEG_OC_CLR       3'b010
`define TEG_OC_TOGGLE    3'b011
`define TEG_OC_FLOW      3'b100
`define TEG_OC_FHIGH     3'b101
`define TEG_OC_PWM1      3'b110
`define TEG_OC_PWM2      3'b111

`endif

/* File: hw/teg_core.v */
// event generation, capture/compare mode and output reference logic of a 16-bit timer
`timescale 1ns/1ps
`include "teg_defs.vh"
module teg_core (
	// clock and reset
	input  wire        clk,
	input  wire        arst_n,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// counter side, same clock
	input  wire [15:0] counter_value,
	input  wire [15:0] auto_reload_value,
	input  wire        count_down,
	input  wire        update_in,
	input  wire        trigger_in,
	input  wire        slave_internal_sel,
	input  wire        internal_trigger_source,
	// pins, asynchronous
	input  wire        timer_input_one,
	input  wire        timer_input_two,
	input  wire        filtered_external_trigger,
	// counter control pulses
	output reg         update_event,
	output reg         prescaler_clear,
	output reg         counter_load,
	output reg  [15:0] counter_load_value,
	output reg         trigger_event,
	output reg         irq_req,
	// channel outputs, bit 0 is channel one
	output reg  [1:0]  chan_output_reference,
	output reg  [1:0]  chan_main_output,
	output reg  [1:0]  chan_complement_output
);

	function sel_level;
		input [1:0] dir;
		input       own;
		input       other;
		input       itrig;
		input       itsel;
		begin
			case (dir)
				`TEG_DIR_OWN:   sel_level = own;
				`TEG_DIR_OTHER: sel_level = other;
				`TEG_DIR_ITRIG: sel_level = itrig & itsel;
				default:        sel_level = 1'b0;
			endcase
		end
	endfunction

	// true while the pwm mode one level would be high, counting up or down
	function pwm_result;
		input        down;
		input [15:0] cnt;
		input [15:0] ccr;
		begin
			if (down)
				pwm_result = !(cnt > ccr);
			else
				pwm_result = (cnt < ccr);
		end
	endfunction

	// two-stage synchronisers for the pins; bit 0/1/2 = input one, two, external trigger
	reg  [2:0]  pin_s1_reg;
	reg  [2:0]  pin_s2_reg;
	reg  [15:0] mode_reg;
	reg  [15:0] ccen_reg;
	reg  [15:0] ien_reg;
	reg         upd_flag_reg;
	reg         trg_flag_reg;
	wire [1:0]  cc_flag;
	wire [1:0]  oc_flag;
	wire [1:0]  ref_now;
	wire [1:0]  pin_on;
	wire [1:0]  pin_pol;
	wire [1:0]  pin_npol;
	wire [15:0] ccr_pre0;
	wire [15:0] ccr_pre1;
	wire        etr_level;
	wire        evt_wr;
	wire        sts_wr;
	wire        upd_strobe;
	wire        trg_strobe;
	wire        upd_any;
	reg  [15:0] rdata_next;
	reg  [15:0] mode_next;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {filtered_external_trigger, timer_input_two, timer_input_one};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign etr_level  = pin_s2_reg[2];
	assign evt_wr     = reg_wr && (reg_addr == `TEG_OFF_EVT);
	assign sts_wr     = reg_wr && (reg_addr == `TEG_OFF_STS);
	assign upd_strobe = evt_wr && reg_wdata[`TEG_BIT_UPD];
	assign trg_strobe = evt_wr && reg_wdata[`TEG_BIT_TRG];
	assign upd_any    = upd_strobe || update_in;

	always @* begin
		mode_next = reg_wdata;
		if (ccen_reg[0])
			mode_next[1:0] = mode_reg[1:0];
		if (ccen_reg[`TEG_CCEN_STRIDE])
			mode_next[9:8] = mode_reg[9:8];
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= `TEG_MODE_RST;
			ccen_reg <= 16'h0000;
			ien_reg  <= 16'h0000;
		end else if (reg_wr) begin
			if (reg_addr == `TEG_OFF_MODE)
				mode_reg <= mode_next;
			if (reg_addr == `TEG_OFF_CCEN)
				ccen_reg <= reg_wdata & `TEG_CCEN_MASK;
			if (reg_addr == `TEG_OFF_IEN)
				ien_reg <= reg_wdata & `TEG_IEN_MASK;
		end
	end

	// flags clear on a written zero; a set in the same cycle wins
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			upd_flag_reg <= 1'b0;
			trg_flag_reg <= 1'b0;
		end else begin
			upd_flag_reg <= upd_any
				|| (upd_flag_reg && !(sts_wr && !reg_wdata[`TEG_BIT_UPD]));
			trg_flag_reg <= trg_strobe || trigger_in
				|| (trg_flag_reg && !(sts_wr && !reg_wdata[`TEG_BIT_TRG]));
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			update_event       <= 1'b0;
			prescaler_clear    <= 1'b0;
			counter_load       <= 1'b0;
			counter_load_value <= 16'h0000;
			trigger_event      <= 1'b0;
			irq_req            <= 1'b0;
		end else begin
			update_event    <= upd_strobe;
			prescaler_clear <= upd_strobe;
			counter_load    <= upd_strobe;
			if (upd_strobe)
				counter_load_value <= count_down ? auto_reload_value : 16'h0000;
			trigger_event <= trg_strobe;
			irq_req <= (upd_flag_reg && ien_reg[`TEG_BIT_UPD])
				|| (trg_flag_reg && ien_reg[`TEG_BIT_TRG])
				|| (|(cc_flag & ien_reg[`TEG_BIT_CC1 +: 2]));
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : ch
			wire [1:0]  dir  = mode_reg[`TEG_MODE_STRIDE*i +: 2];
			wire        fen  = mode_reg[`TEG_MODE_STRIDE*i + 2];
			wire        pen  = mode_reg[`TEG_MODE_STRIDE*i + 3];
			wire [2:0]  md   = mode_reg[`TEG_MODE_STRIDE*i + 4 +: 3];
			wire        cen  = mode_reg[`TEG_MODE_STRIDE*i + 7];
			wire        on   = ccen_reg[`TEG_CCEN_STRIDE*i];
			wire        pol  = ccen_reg[`TEG_CCEN_STRIDE*i + 1];
			wire        npol = ccen_reg[`TEG_CCEN_STRIDE*i + 3];
			wire [7:0]  off  = (i == 0) ? `TEG_OFF_CC1 : `TEG_OFF_CC2;
			wire        is_out = (dir == `TEG_DIR_OUT);
			wire        lvl  = sel_level(dir, pin_s2_reg[i], pin_s2_reg[1-i],
				internal_trigger_source, slave_internal_sel);
			wire        strobe = evt_wr && reg_wdata[`TEG_BIT_CC1 + i];
			wire        wr_cc  = reg_wr && (reg_addr == off);
			wire        rd_cc  = reg_rd && (reg_addr == off) && !is_out;
			reg         lvl_prev_reg;
			reg  [15:0] pre_reg;
			reg  [15:0] act_reg;
			reg         flag_reg;
			reg         oc_reg;
			reg         ref_reg;
			reg         res_prev_reg;
			reg  [2:0]  md_prev_reg;
			reg         ref_next;
			wire        cap_edge = lvl && !lvl_prev_reg;
			wire        cap   = !is_out && (strobe || cap_edge);
			wire        match = is_out && (act_reg == counter_value);
			wire        res   = pwm_result(count_down, counter_value, act_reg);
			wire        pwm_lvl = (md == `TEG_OC_PWM1) ? res : !res;

			assign cc_flag[i] = flag_reg;
			assign oc_flag[i] = oc_reg;
			assign ref_now[i] = ref_reg;
			assign pin_on[i]   = on;
			assign pin_pol[i]  = pol;
			assign pin_npol[i] = npol;

			always @* begin
				ref_next = ref_reg;
				if (cen && etr_level)
					ref_next = 1'b0;
				else begin
					case (md)
						`TEG_OC_FROZEN: ref_next = ref_reg;
						`TEG_OC_SET:    ref_next = match ? 1'b1 : ref_reg;
						`TEG_OC_CLR:    ref_next = match ? 1'b0 : ref_reg;
						`TEG_OC_TOGGLE: ref_next = match ? !ref_reg : ref_reg;
						`TEG_OC_FLOW:   ref_next = 1'b0;
						`TEG_OC_FHIGH:  ref_next = 1'b1;
						default: begin
							if (fen && trigger_in)
								ref_next = (md == `TEG_OC_PWM2);
							else if (res != res_prev_reg || md_prev_reg == `TEG_OC_FROZEN)
								ref_next = pwm_lvl;
						end
					endcase
				end
			end

			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					lvl_prev_reg <= 1'b0;
					pre_reg      <= 16'h0000;
					act_reg      <= 16'h0000;
					flag_reg     <= 1'b0;
					oc_reg       <= 1'b0;
					ref_reg      <= 1'b0;
					res_prev_reg <= 1'b0;
					md_prev_reg  <= `TEG_OC_FROZEN;
				end else begin
					lvl_prev_reg <= lvl;
					res_prev_reg <= res;
					md_prev_reg  <= md;
					ref_reg      <= is_out ? ref_next : 1'b0;
					if (cap)
						pre_reg <= counter_value;
					else if (wr_cc)
						pre_reg <= reg_wdata;
					if (cap)
						act_reg <= counter_value;
					else if (wr_cc && !pen)
						act_reg <= reg_wdata;
					else if (upd_any && pen)
						act_reg <= pre_reg;
					flag_reg <= cap || (is_out && (strobe || match))
						|| (flag_reg && !(sts_wr && !reg_wdata[`TEG_BIT_CC1 + i]) && !rd_cc);
					oc_reg <= (cap && flag_reg)
						|| (oc_reg && !(sts_wr && !reg_wdata[`TEG_BIT_OC1 + i]));
				end
			end

		end
	endgenerate

	// polarity on pins; one process owns every bit of each output vector
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_output_reference  <= 2'b00;
			chan_main_output       <= 2'b00;
			chan_complement_output <= 2'b00;
		end else begin
			chan_output_reference  <= ref_now;
			chan_main_output       <= pin_on & (ref_now ^ pin_pol);
			chan_complement_output <= pin_on & (~ref_now ^ pin_npol);
		end
	end

	// software always sees the preload copy; it equals the active value with preload off
	assign ccr_pre0 = ch[0].pre_reg;
	assign ccr_pre1 = ch[1].pre_reg;

	always @* begin
		case (reg_addr)
			`TEG_OFF_IEN:  rdata_next = ien_reg;
			`TEG_OFF_STS:  rdata_next = {5'h00, oc_flag, 2'h0, trg_flag_reg, 3'h0, cc_flag, upd_flag_reg};
			`TEG_OFF_MODE: rdata_next = mode_reg;
			`TEG_OFF_CCEN: rdata_next = ccen_reg;
			`TEG_OFF_CC1:  rdata_next = ccr_pre0;
			`TEG_OFF_CC2:  rdata_next = ccr_pre1;
			// event register is write-only; unmapped reads return zero
			default:       rdata_next = 16'h0000;
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 16'h0000;
	end

endmodule // teg_core

/* File: verification/teg_chk_sva.sv */
// port assertions for the timer event and compare block
`timescale 1ns/1ps
module teg_chk (
	// clock and reset
	input wire        clk,
	input wire        arst_n,
	// register port
	input wire [7:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	// pin and outputs
	input wire        filtered_external_trigger,
	input wire        update_event,
	input wire        counter_load,
	input wire        trigger_event,
	input wire [1:0]  chan_output_reference,
	input wire [1:0]  chan_main_output,
	input wire [1:0]  chan_complement_output
);
	// channel one fields without direction, so input-mode writes cannot confuse it
	reg  [3:0] md_reg;
	reg  [2:0] en_reg;
	wire       ev = reg_wr && reg_addr == 8'h14;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			md_reg <= 4'h0;
			en_reg <= 3'h0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h18)
				md_reg <= reg_wdata[7:4];
			if (reg_addr == 8'h20)
				en_reg <= {reg_wdata[3], reg_wdata[1:0]};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_update_pulse: assert property (ev && reg_wdata[0] |=> update_event && counter_load)
		else $error("update pulses missing");
	chk_trigger_pulse: assert property (ev && reg_wdata[6] |=> trigger_event)
		else $error("trigger event missing");
	chk_event_read: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 16'h0000)
		else $error("event register read not zero");
	chk_main_level: assert property (chan_main_output[0] ==
		($past(en_reg[0]) & (chan_output_reference[0] ^ $past(en_reg[1]))))
		else $error("main pin level wrong");
	chk_comp_level: assert property (chan_complement_output[0] ==
		($past(en_reg[0]) & (~chan_output_reference[0] ^ $past(en_reg[2]))))
		else $error("complement pin level wrong");
	chk_force_low: assert property ((md_reg[2:0] == 3'h4) [*3] |-> !chan_output_reference[0])
		else $error("forced low reference high");
	chk_ext_clear: assert property ((md_reg[3] && filtered_external_trigger) [*5] |-> !chan_output_reference[0])
		else $error("external clear ignored");
	chk_frozen_hold: assert property ($past(md_reg) == 4'h0 && $past(md_reg, 2) == 4'h0 |->
		$stable(chan_output_reference[0]))
		else $error("frozen reference moved");
	cover property (ev && reg_wdata[0]);
	cover property (md_reg[3] && filtered_external_trigger);
	cover property (md_reg[2:1] == 2'h3 && chan_output_reference[0]);
endmodule // teg_chk
bind teg_core teg_chk u_chk (.*);

/* File: verification/timer_event_gen_and_compare_mode_bench.sv */
// self-checking bench for the timer event and compare block
`timescale 1ns/1ps
module timer_event_gen_and_compare_mode_bench;
	logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, count_down = 0;
	logic        update_in = 0, trigger_in = 0, slave_internal_sel = 0;
	logic        internal_trigger_source = 0, timer_input_one = 0;
	logic        timer_input_two = 0, filtered_external_trigger = 0;
	logic [7:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, counter_value = 16'h0100, auto_reload_value = 0;
	logic [15:0] rdv, r, last, pol;
	logic [2:0]  mk, ch2x = 3'h0;
	wire  [15:0] reg_rdata, counter_load_value;
	wire         update_event, prescaler_clear, counter_load, trigger_event, irq_req;
	wire  [1:0]  chan_output_reference, chan_main_output, chan_complement_output;
	integer      bad_count = 0, cmp_count = 0, seed = 32'h674e_9573, i, m;
	teg_core DUT (.*);
	initial forever #50 clk = ~clk;
	task chk(input string n, input logic [15:0] e, g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 rdv = reg_rdata;
	endtask
	// margin covers the reference register plus the pin register
	task cr(input logic e, input integer n);
		repeat (n) @(posedge clk);
		#1 chk("ref_pins", {10'h000, ch2x, ~e ^ pol[3], e ^ pol[1], e}, {10'h000,
			chan_complement_output[1], chan_main_output[1], chan_output_reference[1],
			chan_complement_output[0], chan_main_output[0], chan_output_reference[0]});
	endtask
	task mt(input [15:0] v);
		@(posedge clk);
		counter_value <= v;
		@(posedge clk);
		counter_value <= 16'h0100;
	endtask
	// pins pass a two-stage synchroniser, so each level is held a while
	task pl(input [2:0] v);
		@(posedge clk);
		{timer_input_one, timer_input_two, internal_trigger_source} <= v;
		repeat (4) @(posedge clk);
		{timer_input_one, timer_input_two, internal_trigger_source} <= 3'h0;
		repeat (4) @(posedge clk);
	endtask
	function logic pe(input integer m, d, c);
		pe = (d ? c <= 16'h0055 : c < 16'h0055) ^ (m == 7);
	endfunction
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1_000_000;
		bad_count++;
		complete_run;
	end
	initial begin
		pol = 16'($random(seed)) & 16'h000A;
		repeat (10) @(posedge clk);
		arst_n <= 1;
		rd(8'h18);
		chk("mode_reset", 16'h0000, rdv);
		wr(8'h0C, 16'h0047);
		wr(8'h20, pol | 16'h0001);
		for (i = 0; i < 2; i++) begin
			m = i ? 2 : 64;
			wr(8'h10, 16'h0000);
			wr(8'h14, m[15:0]);
			#1 chk("trig_event", {15'h0000, !i}, {15'h0000, trigger_event});
			rd(8'h10);
			chk("flags", m[15:0], rdv & 16'h0047);
			rd(8'h14);
			chk("irq_evt", 16'h8000, {irq_req, rdv[14:0]});
		end
		for (i = 0; i < 4; i++) begin
			auto_reload_value <= 16'($random(seed));
			count_down <= i[0];
			wr(8'h14, 16'h0001);
			#1 chk("load", i[0] ? auto_reload_value : 16'h0000, counter_load_value);
			chk("psc", 16'h0001, {15'h0000, prescaler_clear});
		end
		$display("strobe tests done");
		count_down <= 0;
		wr(8'h34, 16'h0055);
		for (m = 1; m < 4; m++) begin
			wr(8'h18, m == 2 ? 16'h0050 : 16'h0040);
			cr(m == 2, 4);
			wr(8'h18, {m[11:0], 4'h0});
			mt(16'h0055);
			cr(m != 2, 4);
		end
		wr(8'h18, 16'h0000);
		mt(16'h0055);
		cr(1, 4);
		for (i = 0; i < 4; i++) begin
			count_down <= i[1];
			r = 16'($random(seed)) & 16'h003F;
			wr(8'h18, 16'h0000);
			counter_value <= r;
			wr(8'h18, i[0] ? 16'h0078 : 16'h0068);
			cr(pe(6 + i[0], i[1], r), 4);
			r = 16'h0056 + (16'($random(seed)) & 16'h00FF);
			counter_value <= r;
			cr(pe(6 + i[0], i[1], r), 4);
		end
		count_down <= 0;
		wr(8'h18, 16'h0000);
		counter_value <= 16'h0010;
		wr(8'h18, 16'h006C);
		cr(1, 4);
		@(posedge clk);
		trigger_in <= 1;
		@(posedge clk);
		trigger_in <= 0;
		cr(0, 2);
		$display("compare tests done");
		wr(8'h18, 16'h0040);
		wr(8'h18, 16'h0010);
		wr(8'h34, 16'h0066);
		mt(16'h0066);
		cr(1, 4);
		wr(8'h18, 16'h0040);
		wr(8'h18, 16'h0018);
		wr(8'h34, 16'h0077);
		rd(8'h34);
		chk("preload", 16'h0077, rdv);
		mt(16'h0077);
		cr(0, 4);
		wr(8'h14, 16'h0001);
		mt(16'h0077);
		cr(1, 4);
		wr(8'h18, 16'h0038);
		wr(8'h34, 16'h0088);
		@(posedge clk);
		update_in <= 1;
		@(posedge clk);
		update_in <= 0;
		mt(16'h0088);
		cr(0, 4);
		wr(8'h18, 16'h00D0);
		filtered_external_trigger <= 1;
		cr(0, 6);
		wr(8'h18, 16'h0050);
		cr(1, 4);
		filtered_external_trigger <= 0;
		wr(8'h20, pol | {pol[11:0], 4'h0} | 16'h0011);
		wr(8'h18, 16'h7850);
		ch2x = {pol[3], ~pol[1], 1'b1};
		cr(1, 4);
		wr(8'h20, pol | 16'h0001);
		$display("preload and clear tests done");
		wr(8'h18, 16'h0100);
		wr(8'h10, 16'h0000);
		for (i = 0; i < 2; i++) begin
			counter_value <= 16'($random(seed));
			wr(8'h14, 16'h0004);
			rd(8'h10);
			chk("cap_flags", i ? 16'h0404 : 16'h0004, rdv & 16'h0404);
		end
		last = counter_value;
		for (i = 0; i < 4; i++) begin
			mk = i == 0 ? 3'h2 : i == 1 ? 3'h4 : 3'h1;
			slave_internal_sel <= i == 3;
			wr(8'h18, i == 0 ? 16'h0100 : i == 1 ? 16'h0200 : 16'h0300);
			counter_value <= 16'h0F0F;
			pl(~mk);
			r = 16'($random(seed));
			counter_value <= r;
			pl(mk);
			if (i != 2)
				last = r;
			rd(8'h38);
			chk("capture", last, rdv);
		end
		wr(8'h20, pol | 16'h0011);
		wr(8'h18, 16'h0000);
		rd(8'h18);
		chk("dir_locked", 16'h0300, rdv);
		$display("capture tests done");
		complete_run;
	end
endmodule // timer_event_gen_and_compare_mode_bench
